// ==== inc/psc_pkg.sv ====
// Purpose: shared constants of the load-switch host controller
// Assumes: 100 MHz clock, 32-bit classic wishbone register port
// Notes: register offsets are byte addresses, one aligned word each
//
// Function
// [RULE1] device flags overvoltage, reverse, thermal, short, overcurrent
// [RULE2] alert line falls after 7ms persistent fault
// [RULE3] alert low, switch off until fault ends
// [RULE4] swap control armed by any swap-pin rising edge
// [RULE5] pulse over 600us: switch on within 60us
// [RULE6] output reaches 90% of input by 60us
// [RULE7] after swap turn-on enable rising edges ignored
// [RULE8] after swap enable falling edge turns device off
// [RULE9] restart needs rising edge on enable or swap
// [RULE10] both discharge pins low: no discharge
// [RULE11] output discharged while output discharge pin high
// [RULE12] input discharged while input discharge pin high
// [RULE13] both pins high: both ports discharged
// [RULE14] reverse voltage turns switch off, recovery on
// [RULE15] overcurrent acts only after 2us above limit
// [RULE16] reverse at pulse end: on once reverse clears
// [RULE17] pulse not over minimum width: no turn-on
package psc_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] REG_SWAP_US = 8'h10;
	// control field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_DISC_IN = 1;
	localparam int CTRL_DISC_OUT = 2;
	localparam int CTRL_SWAP_GO = 3;
	localparam int CTRL_SWAP_OFF = 4;
	// status field positions
	localparam int STAT_FAULT = 0;
	localparam int STAT_SWAPPED = 1;
	localparam int STAT_BUSY = 2;
	// interrupt field positions
	localparam int IRQ_FAULT_SET = 0;
	localparam int IRQ_FAULT_CLR = 1;
	localparam int IRQ_SWAP_DONE = 2;
	localparam int IRQ_BITS = 3;
	// reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 3'h0;
	// timing
	localparam int CLK_NS = 10;
	localparam int US_NS = 1000;
	localparam int TICK_CYC = US_NS / CLK_NS; // cycles per microsecond
	localparam int SWAP_MIN_US = 600; // device minimum pulse width
	localparam int SWAP_DEF_US = 700; // default pulse, clear of the minimum
	localparam int EN_EDGE_NS = 1000; // least hold of enable around an edge
	localparam int EN_EDGE_CYC = (EN_EDGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SWAP_US_W = 16;
	localparam int CNT_W = 24;
endpackage

// ==== src/psc_sync.sv ====
// Purpose: two flip-flop level synchroniser for pin inputs
// Assumes: input changes slowly against clk_i
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic [W-1:0] d_i, // asynchronous level
	output logic [W-1:0] q_o // synchronised level
);
	logic [W-1:0] meta_q; // first stage, may go metastable
	// both stages take the reset value so no glitch leaves at release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // psc_sync
`default_nettype wire

// ==== src/psc_ctrl.sv ====
// Purpose: host controller driving a load switch's enable, swap and discharge pins
// Assumes: classic wishbone slave, one clock, fault_alert_n from an outside pin
// Notes: turning off after a role swap always ends in an enable falling edge
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl
	import psc_pkg::*;
#(
	parameter int TICK = TICK_CYC, // cycles per microsecond, shorten in simulation
	parameter logic [SWAP_US_W-1:0] SWAP_US_RST = SWAP_US_W'(SWAP_DEF_US)
) (
	input wire logic clk_i, // 100 MHz clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic irq_o, // level interrupt
	input wire logic fault_alert_n, // device fault line, low active
	output logic en_o, // device enable pin
	output logic role_swap_pulse_pin, // swap pulse to device
	output logic input_discharge_ctl, // input port discharge pin
	output logic output_discharge_ctl // output port discharge pin
);
	typedef enum logic [2:0] {ST_IDLE, ST_PULSE, ST_SWAPPED, ST_RAISE, ST_DROP} psc_state_t;

	// bus decode
	logic req; // live request
	logic wr_now; // write takes effect on this edge
	logic [31:0] wmask; // byte lanes as a bit mask
	logic [31:0] wdat; // masked write data
	logic [31:0] rd_d; // read mux
	logic ack_d;
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_now = req & wb_we_i & wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat = wb_dat_i & wmask;

	// fault line crossing
	logic alert_n_s; // synchronised alert level
	psc_sync #(.W(1), .RST_VAL(1'b1)) u_alert_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(fault_alert_n),
		.q_o(alert_n_s)
	);
	logic fault_q, fault_d; // last sampled fault level

	// state
	psc_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d; // phase timer
	logic [CNT_W-1:0] pulse_cyc; // pulse length in cycles
	logic en_d, swap_d, din_d, dout_d;
	logic [SWAP_US_W-1:0] swap_us_q, swap_us_d; // pulse width in microseconds
	logic [IRQ_BITS-1:0] ist_q, ist_d, imask_q, imask_d;
	logic irq_d;
	logic [31:0] rd_q;
	logic wr_ctrl; // write to control this edge
	logic go_cmd, off_cmd; // one-shot commands
	logic [IRQ_BITS-1:0] ev; // hardware events

	assign pulse_cyc = CNT_W'(swap_us_q) * CNT_W'(TICK);
	assign wr_ctrl = wr_now & (wb_adr_i == REG_CTRL) & wb_sel_i[0];
	assign go_cmd = wr_ctrl & wb_dat_i[CTRL_SWAP_GO];
	assign off_cmd = wr_ctrl & wb_dat_i[CTRL_SWAP_OFF];

	// read mux, sampled with the acknowledge; unmapped reads give zero
	always_comb begin
		rd_d = 32'h0;
		unique case (wb_adr_i)
			REG_CTRL: begin
				rd_d[CTRL_EN] = en_o;
				rd_d[CTRL_DISC_IN] = input_discharge_ctl;
				rd_d[CTRL_DISC_OUT] = output_discharge_ctl;
			end
			REG_STATUS: begin
				rd_d[STAT_FAULT] = fault_q;
				rd_d[STAT_SWAPPED] = (st_q == ST_SWAPPED);
				rd_d[STAT_BUSY] = (st_q == ST_PULSE) | (st_q == ST_RAISE) | (st_q == ST_DROP);
			end
			REG_IRQ_STAT: rd_d[IRQ_BITS-1:0] = ist_q;
			REG_IRQ_MASK: rd_d[IRQ_BITS-1:0] = imask_q;
			REG_SWAP_US: rd_d[SWAP_US_W-1:0] = swap_us_q;
			default: rd_d = 32'h0;
		endcase
		// ack in the cycle after the request, dropped right after
		ack_d = req & ~wb_ack_o;
	end

	// sequencer and pin levels
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		en_d = en_o;
		swap_d = role_swap_pulse_pin;
		din_d = input_discharge_ctl;
		dout_d = output_discharge_ctl;
		swap_us_d = swap_us_q;
		// discharge pins hold whatever software last wrote
		if (wr_ctrl) begin
			din_d = wb_dat_i[CTRL_DISC_IN]; // [RULE12]
			dout_d = wb_dat_i[CTRL_DISC_OUT]; // [RULE11]
		end
		if (wr_now & (wb_adr_i == REG_SWAP_US)) begin
			swap_us_d = (swap_us_q & ~wmask[SWAP_US_W-1:0]) | wdat[SWAP_US_W-1:0];
		end
		unique case (st_q)
			ST_IDLE: begin
				// a plain enable write gives the restart edge
				if (wr_ctrl) begin
					en_d = wb_dat_i[CTRL_EN]; // [RULE9]
				end
				if (go_cmd) begin
					// rising edge arms the device's swap logic
					swap_d = 1'b1; // [RULE4]
					cnt_d = '0;
					st_d = ST_PULSE;
				end
			end
			ST_PULSE: begin
				// width below the minimum is allowed, the device ignores it
				if (cnt_q + CNT_W'(1) >= pulse_cyc) begin
					swap_d = 1'b0;
					st_d = ST_SWAPPED;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_SWAPPED: begin
				// enable writes are ignored; only an off command leaves
				if (off_cmd) begin
					cnt_d = '0;
					if (en_o) begin
						en_d = 1'b0; // [RULE8]
						st_d = ST_DROP;
					end else begin
						// device ignores this rise, it only sets up the fall
						en_d = 1'b1;
						st_d = ST_RAISE;
					end
				end
			end
			ST_RAISE: begin
				if (cnt_q + CNT_W'(1) >= CNT_W'(EN_EDGE_CYC)) begin
					en_d = 1'b0; // [RULE8]
					cnt_d = '0;
					st_d = ST_DROP;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_DROP: begin
				// keep enable low long enough before a restart edge
				if (cnt_q + CNT_W'(1) >= CNT_W'(EN_EDGE_CYC)) begin
					st_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
		endcase
	end

	// events and interrupt; a set in the clearing cycle wins
	always_comb begin
		fault_d = ~alert_n_s;
		ev = '0;
		ev[IRQ_FAULT_SET] = fault_d & ~fault_q;
		ev[IRQ_FAULT_CLR] = ~fault_d & fault_q;
		ev[IRQ_SWAP_DONE] = (st_q == ST_PULSE) & (st_d == ST_SWAPPED);
		ist_d = ist_q;
		imask_d = imask_q;
		if (wr_now & (wb_adr_i == REG_IRQ_STAT)) begin
			ist_d = ist_q & ~wdat[IRQ_BITS-1:0];
		end
		if (wr_now & (wb_adr_i == REG_IRQ_MASK)) begin
			imask_d = (imask_q & ~wmask[IRQ_BITS-1:0]) | wdat[IRQ_BITS-1:0];
		end
		ist_d = ist_d | ev;
		irq_d = |(ist_d & imask_d);
	end

	// registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			en_o <= CTRL_RST[CTRL_EN];
			role_swap_pulse_pin <= 1'b0;
			input_discharge_ctl <= CTRL_RST[CTRL_DISC_IN];
			output_discharge_ctl <= CTRL_RST[CTRL_DISC_OUT];
			swap_us_q <= SWAP_US_RST;
			fault_q <= 1'b0;
			ist_q <= '0;
			imask_q <= IRQ_MASK_RST;
			irq_o <= 1'b0;
			wb_ack_o <= 1'b0;
			rd_q <= 32'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			en_o <= en_d;
			role_swap_pulse_pin <= swap_d;
			input_discharge_ctl <= din_d;
			output_discharge_ctl <= dout_d;
			swap_us_q <= swap_us_d;
			fault_q <= fault_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			irq_o <= irq_d;
			wb_ack_o <= ack_d;
			rd_q <= rd_d;
		end
	end
	assign wb_dat_o = rd_q;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [CNT_W-1:0] hi_cnt_q; // swap pin high time seen by the checks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hi_cnt_q <= '0;
		end else begin
			hi_cnt_q <= role_swap_pulse_pin ? hi_cnt_q + CNT_W'(1) : '0;
		end
	end
	a_disc_in_hold: assert property (!wr_ctrl && input_discharge_ctl |=> input_discharge_ctl) // [RULE12]
		else $error("input discharge dropped without a write");
	a_disc_out_set: assert property (wr_ctrl && wb_dat_i[CTRL_DISC_OUT] |=> output_discharge_ctl) // [RULE11]
		else $error("output discharge not raised");
	a_off_ends_low: assert property ($rose(off_cmd && st_q == ST_SWAPPED) |-> ##[1:2] (st_q == ST_RAISE || st_q == ST_DROP) ##0 1'b1) // [RULE8]
		else $error("off command did not start shutdown");
	a_drop_en_low: assert property (st_q == ST_DROP |-> !en_o) // [RULE8]
		else $error("enable high while dropping");
	a_idle_en_hold: assert property (st_q == ST_IDLE && !wr_ctrl && !en_o |=> !en_o) // [RULE9]
		else $error("enable rose without a command");
	// at the falling sample the counter already holds the full high time
	a_swap_width: assert property ($fell(role_swap_pulse_pin) |-> hi_cnt_q == pulse_cyc) // [RULE4]
		else $error("swap pulse width wrong");
	a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	c_swap_done: cover property (st_q == ST_PULSE ##1 st_q == ST_SWAPPED);
	c_off_raise: cover property (st_q == ST_RAISE ##[1:200] st_q == ST_DROP);
	c_fault_irq: cover property ($rose(irq_o) && ist_q[IRQ_FAULT_SET]);
endmodule // psc_ctrl
`default_nettype wire

// ==== bench/psc_dev_model.sv ====
// Purpose: behavioural load switch that answers the host controller's pins
// Assumes: one clock, times scaled to TICK cycles per us, deglitch shortened
// Notes: the alert line has a pull-up, so a released line reads 1
`timescale 1ns/1ps
`default_nettype none
module psc_dev_model #(
	parameter int TICK = 1, // cycles per microsecond
	parameter int GLITCH = 20 // deglitch span in cycles
) (
	input wire logic clk_i, // clock
	input wire logic en_i, // enable pin
	input wire logic swap_i, // swap pulse pin
	input wire logic disc_in_i, // input discharge pin
	input wire logic disc_out_i, // output discharge pin
	input wire logic cond_i, // any protection condition except reverse, already qualified
	input wire logic rev_i, // reverse voltage present
	output logic alert_n_o, // fault line, low active
	output logic sw_on_o, // pass switch on
	output logic dis_in_o, // input port discharging
	output logic dis_out_o // output port discharging
);
	logic en_q = 1'b0; // last enable level
	logic sw_q = 1'b0; // last swap level
	logic run_q = 1'b0; // device active
	logic frs_q = 1'b0; // swap turn-on happened
	int wid_q = 0; // swap pulse width so far
	int flt_q = 0; // cycles the condition has lasted
	// output level is taken as full at once, the analog ramp is not modelled
	assign sw_on_o = run_q && !cond_i && !rev_i;
	assign alert_n_o = (flt_q >= GLITCH) ? 1'b0 : 1'b1;
	assign dis_in_o = disc_in_i;
	assign dis_out_o = disc_out_i;
	// edge detection on the pins and the swap sequencer
	always @(posedge clk_i) begin
		en_q <= en_i;
		sw_q <= swap_i;
		flt_q <= cond_i ? flt_q + 1 : 0;
		if (swap_i) begin // armed whatever enable does
			wid_q <= sw_q ? wid_q + 1 : 1;
		end
		if (!swap_i && sw_q && wid_q > 600 * TICK) begin
			frs_q <= 1'b1;
			run_q <= 1'b1;
		end else if (frs_q && !en_i && en_q) begin
			frs_q <= 1'b0;
			run_q <= 1'b0;
		end else if (!frs_q && en_i != en_q) begin // rises ignored while swapped
			run_q <= en_i;
		end
	end
endmodule // psc_dev_model
`default_nettype wire

// ==== bench/tb_psc_ctrl.sv ====
// Purpose: self-checking bench of the load-switch host controller
// Assumes: TICK of 1, so one microsecond is one cycle
// Notes: all bus traffic goes through task wb
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_psc_ctrl;
	import psc_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, alert_n, en, swp, din, dout;
	logic cond, rev, sw_on, dis_in, dis_out;
	logic [3:0] sel;
	logic [7:0] adr;
	logic [31:0] dat, rdat, rdv;
	int fails = 0;
	int checked = 0;
	psc_ctrl #(.TICK(1)) u_psc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .fault_alert_n(alert_n), .en_o(en),
		.role_swap_pulse_pin(swp), .input_discharge_ctl(din), .output_discharge_ctl(dout));
	psc_dev_model #(.TICK(1)) u_psc_dev_model (.clk_i(clk_i), .en_i(en), .swap_i(swp),
		.disc_in_i(din), .disc_out_i(dout), .cond_i(cond), .rev_i(rev),
		.alert_n_o(alert_n), .sw_on_o(sw_on), .dis_in_o(dis_in), .dis_out_o(dis_out));
	// free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle: hold until ack is sampled high, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		sel <= 4'hF;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK("read", e, rdv)
	endtask
	task automatic print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// hang guard, far beyond the roughly 1400 cycles the tests need
	initial begin
		wt(20000);
		fails++;
		print_verdict();
	end
	initial begin
		{rst_i, cyc, stb, we, cond, rev} = 6'h20;
		adr = 8'h00;
		dat = 32'h0;
		sel = 4'hF;
		wt(8);
		rst_i <= 1'b0;
		wt(2);
		rdchk(REG_SWAP_US, 32'h0000_02BC);
		rdchk(8'h40, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, REG_CTRL, 32'(i) << 1);
			`CHK("in discharge", i[0], dis_in)
			`CHK("out discharge", i[1], dis_out)
		end
		$display("test discharge done");
		wb(1'b1, REG_IRQ_MASK, 32'h7);
		wb(1'b1, REG_CTRL, 32'h1);
		wt(2);
		`CHK("switch", 1'b1, sw_on)
		cond <= 1'b1;
		wt(10);
		cond <= 1'b0;
		// one clean cycle must restart the deglitch count
		wt(1);
		`CHK("alert", 1'b1, alert_n)
		cond <= 1'b1;
		wt(15);
		`CHK("alert", 1'b1, alert_n)
		wt(15);
		`CHK("alert", 1'b0, alert_n)
		`CHK("switch", 1'b0, sw_on)
		`CHK("irq", 1'b1, irq)
		rdchk(REG_STATUS, 32'h1);
		cond <= 1'b0;
		wt(5);
		`CHK("switch", 1'b1, sw_on)
		rdchk(REG_IRQ_STAT, 32'h3);
		wb(1'b1, REG_IRQ_STAT, 32'h3);
		`CHK("irq", 1'b0, irq)
		wb(1'b1, REG_CTRL, 32'h0);
		$display("test fault done");
		wb(1'b1, REG_SWAP_US, 32'h3);
		wb(1'b1, REG_CTRL, 32'h8);
		wt(10);
		`CHK("switch", 1'b0, sw_on)
		rdchk(REG_IRQ_STAT, 32'h4);
		wb(1'b1, REG_IRQ_STAT, 32'h4);
		wb(1'b1, REG_CTRL, 32'h10);
		wt(220);
		wb(1'b1, REG_SWAP_US, 32'h0000_02BC);
		rev <= 1'b1;
		wb(1'b1, REG_CTRL, 32'h8);
		wt(5);
		`CHK("swap pin", 1'b1, swp)
		wt(720);
		`CHK("switch", 1'b0, sw_on)
		rdchk(REG_STATUS, 32'h2);
		rdchk(REG_IRQ_STAT, 32'h4);
		`CHK("irq", 1'b1, irq)
		rev <= 1'b0;
		wt(2);
		`CHK("switch", 1'b1, sw_on)
		wb(1'b1, REG_CTRL, 32'h10);
		wt(50);
		`CHK("enable", 1'b1, en)
		`CHK("switch", 1'b1, sw_on)
		wt(100);
		`CHK("switch", 1'b0, sw_on)
		wt(110);
		wb(1'b1, REG_CTRL, 32'h1);
		wt(3);
		`CHK("switch", 1'b1, sw_on)
		$display("test swap done");
		print_verdict();
	end
endmodule // tb_psc_ctrl
`default_nettype wire
